// ===== timer2_control_logic.sv
// timer 2 control register, counter and overflow flags
// assumes a bit-addressable special register port and a 250 MHz clock
`default_nettype none

module timer2_control_logic
  import timer2_pkg::*;
#(
  parameter int SDIV = SYS_DIV,
  parameter int RDIV = RTC_DIV
)
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // special register byte access
  input  wire logic [7:0]  i_sfr_addr,
  input  wire logic        i_sfr_wr,
  input  wire logic [7:0]  i_sfr_wdata,
  output logic      [7:0]  o_sfr_rdata,
  // bit access
  input  wire logic        i_bit_wr,
  input  wire logic [7:0]  i_bit_addr,
  input  wire logic        i_bit_wdata,
  // clock control bits held elsewhere
  input  wire logic        i_high_byte_clock_select,
  input  wire logic        i_low_byte_clock_select,
  // interrupt enable from the processor
  input  wire logic        i_irq_enable,
  // external sources
  input  wire logic        i_rtc_clk,
  input  wire logic        i_cmp0,
  // reload value
  input  wire logic [15:0] i_reload,
  // status
  output logic      [15:0] o_count,
  output logic      [15:0] o_capture,
  output logic             o_irq
);

  function automatic logic bit_hit(input logic [7:0] addr);
    bit_hit = (addr[7:BIT_SEL_W] == CTRL_ADDR[7:BIT_SEL_W]);
  endfunction : bit_hit

  ctrl_type    ctrl;
  ctrl_type    next_ctrl;
  tick_type    tick;
  logic        sw_write;
  logic        lo_tick;
  logic        hi_tick;
  logic        lo_en;
  logic        hi_en;
  logic        wrap_lo;
  logic        wrap_hi;
  logic        cap_event;
  logic [15:0] next_count;

  timer2_clock_sources #(
    .SDIV (SDIV),
    .RDIV (RDIV)
  ) i_timer2_clock_sources (
    .i_clk     (i_clk),
    .i_rstn    (i_rstn),
    .i_rtc_clk (i_rtc_clk),
    .i_cmp0    (i_cmp0),
    .i_xsel    (ctrl.ext_clock_select),
    .o_tick    (tick)
  );

  // per-byte clock choice
  assign lo_tick = i_low_byte_clock_select  ? 1'b1 : tick.ext;
  assign hi_tick = i_high_byte_clock_select ? 1'b1 : tick.ext;

  // count enables
  assign lo_en = ctrl.split_mode_select ? lo_tick
               : (ctrl.run_control && lo_tick);
  assign hi_en = ctrl.split_mode_select
               ? (ctrl.run_control && hi_tick)
               : lo_en;

  assign wrap_lo   = lo_en && (o_count[7:0] == BYTE_MAX);
  assign wrap_hi   = ctrl.split_mode_select
                   ? (hi_en && (o_count[15:8] == BYTE_MAX))
                   : (lo_en && (o_count == WORD_MAX));
  assign cap_event = ctrl.capture_mode_enable && tick.cap;

  assign sw_write = (i_sfr_wr && (i_sfr_addr == CTRL_ADDR))
                 || (i_bit_wr && bit_hit(i_bit_addr));

  // counter next value with auto-reload
  always_comb
  begin
    next_count = o_count;
    if (ctrl.split_mode_select)
    begin
      if (lo_en)
        next_count[7:0] = wrap_lo ? i_reload[7:0]
                        : 8'(o_count[7:0] + BYTE_ONE);
      if (hi_en)
        next_count[15:8] = wrap_hi ? i_reload[15:8]
                         : 8'(o_count[15:8] + BYTE_ONE);
    end
    else if (lo_en)
      next_count = wrap_hi ? i_reload : 16'(o_count + 16'h0001);
  end

  // control register next value, hardware set wins
  always_comb
  begin
    logic [7:0] bits;
    bits      = ctrl;
    next_ctrl = ctrl;
    if (i_sfr_wr && (i_sfr_addr == CTRL_ADDR))
      next_ctrl = ctrl_type'(i_sfr_wdata);
    else if (i_bit_wr && bit_hit(i_bit_addr))
    begin
      bits[i_bit_addr[BIT_SEL_W-1:0]] = i_bit_wdata;
      next_ctrl = ctrl_type'(bits);
    end
    if (wrap_hi || cap_event)
      next_ctrl.high_overflow_flag = 1'b1;
    if (wrap_lo)
      next_ctrl.low_overflow_flag = 1'b1;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      ctrl <= ctrl_type'(CTRL_RESET);
    else
      ctrl <= next_ctrl;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      o_count <= WORD_RESET;
    else
      o_count <= next_count;
  end

  // capture latch
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      o_capture <= WORD_RESET;
    else if (cap_event)
      o_capture <= o_count;
  end

  // read data and interrupt request
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      o_sfr_rdata <= CTRL_RESET;
    else
      o_sfr_rdata <= ctrl;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      o_irq <= 1'b0;
    else
      o_irq <= i_irq_enable && (ctrl.high_overflow_flag
            || (ctrl.low_byte_irq_enable && ctrl.low_overflow_flag));
  end

  // checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  chk_flag_sticky: assert property (
    ctrl.high_overflow_flag && !sw_write |=> ctrl.high_overflow_flag)
    else $error("high flag cleared without a write");

  chk_low_wrap_flag: assert property (
    wrap_lo |=> ctrl.low_overflow_flag
      && (!$past(ctrl.split_mode_select)
          || o_count[7:0] == $past(i_reload[7:0])))
    else $error("low wrap did not set flag or reload");

  chk_split_high_wrap: assert property (
    ctrl.split_mode_select && hi_en && o_count[15:8] == BYTE_MAX
    |=> ctrl.high_overflow_flag)
    else $error("split high wrap did not set flag");

  chk_word_wrap: assert property (
    !ctrl.split_mode_select && lo_en && o_count == WORD_MAX
    |=> ctrl.high_overflow_flag && o_count == $past(i_reload))
    else $error("word wrap did not set flag or reload");

  chk_hold_stopped: assert property (
    !ctrl.run_control && !ctrl.split_mode_select |=> $stable(o_count))
    else $error("counter moved while stopped");

  chk_split_low_free: assert property (
    ctrl.split_mode_select && lo_tick && o_count[7:0] != BYTE_MAX
    |=> o_count[7:0] == 8'($past(o_count[7:0]) + BYTE_ONE))
    else $error("split low byte did not count");

  chk_irq_high: assert property (
    i_irq_enable && ctrl.high_overflow_flag |=> o_irq)
    else $error("high flag interrupt missing");

  chk_irq_low: assert property (
    i_irq_enable && ctrl.low_byte_irq_enable && ctrl.low_overflow_flag
    |=> o_irq)
    else $error("low flag interrupt missing");

  chk_capture_value: assert property (
    cap_event |=> o_capture == $past(o_count) && ctrl.high_overflow_flag)
    else $error("capture value wrong");

  cov_word_wrap:  cover property (!ctrl.split_mode_select && wrap_hi);
  cov_split_high: cover property (ctrl.split_mode_select && wrap_hi);
  cov_capture:    cover property (cap_event);

endmodule : timer2_control_logic

`default_nettype wire

// ===== timer2_pkg.sv
// shared constants and types for the timer 2 control block
// assumes a single 250 MHz system clock and an 8-bit special register bus
`default_nettype none

package timer2_pkg;

  // control register location and reset value
  localparam logic [7:0]  CTRL_ADDR     = 8'hC8;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam int          BIT_SEL_W     = 3;

  // counter limits
  localparam logic [7:0]  BYTE_MAX      = 8'hFF;
  localparam logic [15:0] WORD_MAX      = 16'hFFFF;
  localparam logic [15:0] WORD_RESET    = 16'h0000;
  localparam logic [7:0]  BYTE_ONE      = 8'h01;

  // clock source dividers
  localparam int          SYS_DIV       = 12;
  localparam int          RTC_DIV       = 8;

  // external clock select codes
  localparam logic [1:0]  XSEL_SYS_RTC  = 2'h0;
  localparam logic [1:0]  XSEL_SYS_CMP  = 2'h1;
  localparam logic [1:0]  XSEL_UNDEF    = 2'h2;
  localparam logic [1:0]  XSEL_RTC_CMP  = 2'h3;

  // control register layout, msb first
  typedef struct packed {
    logic       high_overflow_flag;
    logic       low_overflow_flag;
    logic       low_byte_irq_enable;
    logic       capture_mode_enable;
    logic       split_mode_select;
    logic       run_control;
    logic [1:0] ext_clock_select;
  } ctrl_type;

  // one-cycle source pulses
  typedef struct packed {
    logic ext;
    logic cap;
  } tick_type;

endpackage : timer2_pkg

`default_nettype wire

// ===== timer2_clock_sources.sv
// external clock and capture trigger pulse generation
// assumes rtc clock and comparator inputs are asynchronous levels
`default_nettype none

module timer2_clock_sources
  import timer2_pkg::*;
#(
  parameter int SDIV = SYS_DIV,
  parameter int RDIV = RTC_DIV
)
(
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  // raw sources
  input  wire logic       i_rtc_clk,
  input  wire logic       i_cmp0,
  // selection
  input  wire logic [1:0] i_xsel,
  // pulses
  output var tick_type    o_tick
);

  localparam int SW = $clog2(SDIV);
  localparam int RW = $clog2(RDIV);

  if (SDIV < 2 || RDIV < 2)
  begin : g_bad
    $error("divider values below two are not supported");
  end

  logic [1:0]    meta;
  logic [1:0]    sync;
  logic [1:0]    prev;
  logic [1:0]    rise;
  logic [SW-1:0] sys_cnt;
  logic [RW-1:0] rtc_cnt;
  logic          sys_pulse;
  logic          rtc_pulse;
  logic          cmp_pulse;

  // two-stage synchronisers, index 0 rtc, 1 comparator
  for (genvar g = 0; g < 2; g++)
  begin : g_sync
    always_ff @(posedge i_clk)
    begin
      if (!i_rstn)
      begin
        meta[g] <= 1'b0;
        sync[g] <= 1'b0;
        prev[g] <= 1'b0;
      end
      else
      begin
        meta[g] <= (g == 0) ? i_rtc_clk : i_cmp0;
        sync[g] <= meta[g];
        prev[g] <= sync[g];
      end
    end
    assign rise[g] = sync[g] & ~prev[g];
  end

  // system clock divided by twelve
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      sys_cnt <= '0;
    else if (sys_cnt == SW'(SDIV - 1))
      sys_cnt <= '0;
    else
      sys_cnt <= SW'(sys_cnt + 1'b1);
  end

  // rtc clock divided by eight, counted on synced edges
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      rtc_cnt <= '0;
    else if (rise[0])
      rtc_cnt <= (rtc_cnt == RW'(RDIV - 1)) ? '0 : RW'(rtc_cnt + 1'b1);
  end

  assign sys_pulse = (sys_cnt == SW'(SDIV - 1));
  assign rtc_pulse = rise[0] && (rtc_cnt == RW'(RDIV - 1));
  assign cmp_pulse = rise[1];

  // source selection, code 10 treated like 01
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      o_tick <= '0;
    else
    begin
      case (i_xsel)
        XSEL_SYS_RTC: o_tick <= '{ext: sys_pulse, cap: rtc_pulse};
        XSEL_SYS_CMP: o_tick <= '{ext: sys_pulse, cap: cmp_pulse};
        XSEL_RTC_CMP: o_tick <= '{ext: rtc_pulse, cap: cmp_pulse};
        XSEL_UNDEF:   o_tick <= '{ext: sys_pulse, cap: cmp_pulse};
        default:      o_tick <= '0;
      endcase
    end
  end

endmodule : timer2_clock_sources

`default_nettype wire

// ===== timer2_control_logic_tb.sv
// self-checking bench for the timer 2 control block
// assumes the design drives o_sfr_rdata two edges after a register write
`default_nettype none

module timer2_control_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import timer2_pkg::*;

  logic        i_clk, i_rstn, i_sfr_wr, i_bit_wr, i_bit_wdata;
  logic        i_high_byte_clock_select, i_low_byte_clock_select;
  logic        i_irq_enable, i_rtc_clk, i_cmp0, o_irq;
  logic [7:0]  i_sfr_addr, i_sfr_wdata, i_bit_addr, o_sfr_rdata;
  logic [15:0] i_reload, o_count, o_capture, v;
  int          bad_count, tests_run;

  timer2_control_logic #(.SDIV(4), .RDIV(2)) i_timer2_control_logic (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_sfr_addr(i_sfr_addr),
    .i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata),
    .o_sfr_rdata(o_sfr_rdata), .i_bit_wr(i_bit_wr),
    .i_bit_addr(i_bit_addr), .i_bit_wdata(i_bit_wdata),
    .i_high_byte_clock_select(i_high_byte_clock_select),
    .i_low_byte_clock_select(i_low_byte_clock_select),
    .i_irq_enable(i_irq_enable), .i_rtc_clk(i_rtc_clk),
    .i_cmp0(i_cmp0), .i_reload(i_reload), .o_count(o_count),
    .o_capture(o_capture), .o_irq(o_irq));

  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick

  task automatic chk(input string nm, input logic [15:0] s, e);
    tests_run++;
    if (s !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out

  task automatic wr_byte(input logic [7:0] d);
    i_sfr_addr  = CTRL_ADDR;
    i_sfr_wdata = d;
    i_sfr_wr    = 1'b1;
    tick(1);
    i_sfr_wr    = 1'b0;
    i_sfr_addr  = 8'h00;
    tick(2);
  endtask : wr_byte

  task automatic wr_bit(input logic [7:0] n, input logic b);
    i_bit_addr  = CTRL_ADDR + n;
    i_bit_wdata = b;
    i_bit_wr    = 1'b1;
    tick(1);
    i_bit_wr    = 1'b0;
    tick(2);
  endtask : wr_bit

  task automatic wait_bit(input int b, input int lim);
    int i;
    for (i = 0; i < lim && o_sfr_rdata[b] !== 1'b1; i++)
      tick(1);
    if (i == lim)
    begin
      bad_count++;
      $display("mismatch wait_bit expected 1 seen 0");
      close_out();
    end
  endtask : wait_bit

  task automatic t_reset_hold;
    chk("rdata_reset", o_sfr_rdata, CTRL_RESET);
    tick(10);
    chk("count_held", o_count, WORD_RESET);
    chk("irq_reset", o_irq, 0);
  endtask : t_reset_hold

  task automatic t_split;
    i_reload = 16'h40F0;
    wr_byte(8'h08);
    wait_bit(6, 400);
    chk("high_idle", o_count[15:8], 0);
    chk("low_reload", o_count[7:4], 4'hF);
    chk("hf_clear", o_sfr_rdata[7], 0);
    wr_bit(2, 1'b1);
    wait_bit(7, 400);
    chk("high_reload", o_count[15:12], 4'h4);
    wr_bit(2, 1'b0);
    v = o_count;
    tick(20);
    chk("high_held", o_count[15:8], v[15:8]);
    chk("low_runs", o_count[7:0] !== v[7:0], 1);
    chk("flags_stay", o_sfr_rdata[7:6], 2'b11);
  endtask : t_split

  task automatic t_irq;
    i_irq_enable = 1'b1;
    tick(3);
    chk("irq_high", o_irq, 1);
    wr_bit(7, 1'b0);
    tick(2);
    chk("hf_cleared", o_sfr_rdata[7], 0);
    chk("irq_low_off", o_irq, 0);
    wr_bit(5, 1'b1);
    tick(2);
    chk("irq_low_on", o_irq, 1);
    i_irq_enable = 1'b0;
    tick(3);
    chk("irq_gated", o_irq, 0);
  endtask : t_irq

  task automatic t_word;
    i_reload = 16'hFFF0;
    wr_byte(8'h04);
    wait_bit(7, 70000);
    chk("word_reload", o_count[15:4], 12'hFFF);
    chk("lf_word", o_sfr_rdata[6], 1);
  endtask : t_word

  task automatic t_ext;
    logic [15:0] d;
    logic        ok;
    i_reload = 16'h0000;
    i_low_byte_clock_select = 1'b0;
    for (int x = 0; x < 4; x++)
    begin
      wr_byte(8'h04 | x[7:0]);
      tick(4);
      v = o_count;
      tick(40);
      d = o_count - v;
      ok = d + 1 >= (x < 3 ? 10 : 0) && d <= (x < 3 ? 11 : 1);
      chk("ext_rate", ok, 1);
    end
    v = o_count;
    repeat (8)
    begin
      i_rtc_clk = 1'b1;
      tick(2);
      i_rtc_clk = 1'b0;
      tick(2);
    end
    tick(6);
    d = o_count - v;
    chk("rtc_rate", d >= 3 && d <= 5, 1);
  endtask : t_ext

  task automatic t_capture;
    wr_byte(8'h05);
    i_cmp0 = 1'b1;
    tick(10);
    chk("no_capture", o_sfr_rdata[7], 0);
    i_cmp0 = 1'b0;
    wr_byte(8'h15);
    i_cmp0 = 1'b1;
    wait_bit(7, 20);
    v = o_count - o_capture;
    chk("capture_val", v <= 16'h0002, 1);
  endtask : t_capture

  initial
  begin
    i_rstn = 1'b0;
    {i_sfr_wr, i_bit_wr, i_bit_wdata, i_irq_enable} = 4'h0;
    {i_rtc_clk, i_cmp0} = 2'h0;
    {i_sfr_addr, i_sfr_wdata, i_bit_addr} = 24'h000000;
    i_high_byte_clock_select = 1'b1;
    i_low_byte_clock_select  = 1'b1;
    i_reload = 16'h0000;
    tick(16);
    i_rstn = 1'b1;
    tick(1);
    t_reset_hold();
    t_split();
    t_irq();
    t_word();
    t_ext();
    t_capture();
    close_out();
  end

endmodule : timer2_control_logic_tb

`default_nettype wire
